/* File: core/cmpm_int_pulse.sv */
// Interrupt line shaper: single pulse or pulse train
`timescale 1ns/1ps
module cmpm_int_pulse
   import cmpm_pkg::*;
#(
   parameter int PULSE_CYCLES = INT_PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic trigger,
   input wire logic trainMode,
   input wire logic stop,
   output logic pulseOut
);
   localparam logic [PULSE_CNT_W-1:0] LAST = PULSE_CNT_W'(PULSE_CYCLES - 1);

   cmpm_pulse_state_t state_reg;
   logic [PULSE_CNT_W-1:0] count_reg;
   logic countDone;
   logic stopPend_reg;
   logic stopSeen;

   assign countDone = (count_reg == LAST);
   assign stopSeen = stop || stopPend_reg;

   // Stop seen during the high phase ends the train after that pulse
   always_ff @(posedge clk) begin
      if (reset || state_reg == PULSE_IDLE) begin
         stopPend_reg <= 1'b0;
      end else if (stop) begin
         stopPend_reg <= 1'b1;
      end
   end

   // Trigger wins over a stop arriving in the same idle cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= PULSE_IDLE;
      end else begin
         unique case (state_reg)
            PULSE_IDLE: begin
               if (trigger) begin
                  state_reg <= PULSE_HIGH;
               end
            end
            PULSE_HIGH: begin
               if (countDone) begin
                  state_reg <= (trainMode && !stopSeen) ? PULSE_LOW : PULSE_IDLE;
               end
            end
            PULSE_LOW: begin
               if (stopSeen || !trainMode) begin
                  state_reg <= PULSE_IDLE;
               end else if (countDone) begin
                  state_reg <= PULSE_HIGH;
               end
            end
            default: begin
               state_reg <= PULSE_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         count_reg <= '0;
      end else if (state_reg == PULSE_IDLE || countDone) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_reg + 1'b1;
      end
   end

   // Active high for the whole high phase
   always_ff @(posedge clk) begin
      if (reset) begin
         pulseOut <= 1'b0;
      end else begin
         pulseOut <= (state_reg == PULSE_IDLE && trigger)
            || (state_reg == PULSE_HIGH && !countDone)
            || (state_reg == PULSE_LOW && countDone && trainMode && !stopSeen);
      end
   end
endmodule

/* File: core/cmpm_pin_mux.sv */
// Multi-function pin multiplexer with APB register slave
`timescale 1ns/1ps
module cmpm_pin_mux
   import cmpm_pkg::*;
#(
   parameter int PULSE_CYCLES = INT_PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic spiMode,
   input wire logic spiReadOe,
   input wire logic spiReadData,
   input wire logic priDataOut,
   input wire logic secDataOut,
   input wire logic dividedClockOut,
   input wire logic recWordClk,
   input wire logic secBitClk,
   input wire logic secWordClk,
   input wire logic dmicClk,
   input wire logic intOneEvent,
   input wire logic intTwoEvent,
   input wire logic flagsRead,
   input wire logic genPinIn,
   output logic genPinOut,
   output logic genPinOe,
   input wire logic dataInPinIn,
   output logic genPinRx,
   output logic dataInPinRx,
   output logic dataOutPinOut,
   output logic dataOutPinOe,
   output logic dataOutKeeperEn,
   output logic spiOutPinOut,
   output logic spiOutPinOe,
   output logic interruptLineOne,
   output logic interruptLineTwo
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   typedef enum logic [2:0] {
      SEL_NONE, SEL_GEN, SEL_DOUT, SEL_DIN, SEL_SPI, SEL_PULSE
   } cmpm_sel_t;

   function automatic cmpm_sel_t decodeAddr(input logic [31:0] addr);
      cmpm_sel_t sel;
      sel = SEL_NONE;
      if (addr[1:0] == 2'h0 && addr[31:10] == 22'h0) begin
         if (addr[9:2] == IDX_GENERAL_PIN) sel = SEL_GEN;
         else if (addr[9:2] == IDX_DATA_OUT_PIN) sel = SEL_DOUT;
         else if (addr[9:2] == IDX_DATA_IN_PIN) sel = SEL_DIN;
         else if (addr[9:2] == IDX_SPI_OUT_PIN) sel = SEL_SPI;
         else if (addr[9:2] == IDX_INT_PULSE_CTRL) sel = SEL_PULSE;
      end
      return sel;
   endfunction

   cmpm_sel_t addrSel;
   logic writeStrobe;

   assign addrSel = decodeAddr(paddr);
   assign writeStrobe = psel && penable && pready && pwrite;

   ////////////////////////////////////////////////////////////////////////////
   // Control registers

   logic [3:0] genFunc_reg;
   logic genGpo_reg;
   logic dataOutKeeperOff_reg;
   logic [2:0] dataOutMux_reg;
   logic dataOutGpo_reg;
   logic [1:0] dataInFunc_reg;
   logic [3:0] spiFunc_reg;
   logic spiGpo_reg;
   logic trainOne_reg;
   logic trainTwo_reg;

   // Only defined fields are stored, so reserved bits cannot be set
   always_ff @(posedge clk) begin
      if (reset) begin
         genFunc_reg <= GEN_FUNC_RESET;
         genGpo_reg <= GEN_GPO_RESET;
      end else if (writeStrobe && addrSel == SEL_GEN) begin
         genFunc_reg <= pwdata[GEN_FUNC_LSB +: 4];
         genGpo_reg <= pwdata[GEN_GPO_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dataOutKeeperOff_reg <= DOUT_KEEPER_RESET;
         dataOutMux_reg <= DOUT_MUX_RESET;
         dataOutGpo_reg <= DOUT_GPO_RESET;
      end else if (writeStrobe && addrSel == SEL_DOUT) begin
         dataOutKeeperOff_reg <= pwdata[DOUT_KEEPER_BIT];
         dataOutMux_reg <= pwdata[DOUT_MUX_LSB +: 3];
         dataOutGpo_reg <= pwdata[DOUT_GPO_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dataInFunc_reg <= DIN_FUNC_RESET;
      end else if (writeStrobe && addrSel == SEL_DIN) begin
         dataInFunc_reg <= pwdata[DIN_FUNC_LSB +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         spiFunc_reg <= SPI_FUNC_RESET;
         spiGpo_reg <= SPI_GPO_RESET;
      end else if (writeStrobe && addrSel == SEL_SPI) begin
         spiFunc_reg <= pwdata[SPI_FUNC_LSB +: 4];
         spiGpo_reg <= pwdata[SPI_GPO_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         trainOne_reg <= TRAIN_RESET;
         trainTwo_reg <= TRAIN_RESET;
      end else if (writeStrobe && addrSel == SEL_PULSE) begin
         trainOne_reg <= pwdata[TRAIN_ONE_BIT];
         trainTwo_reg <= pwdata[TRAIN_TWO_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchronisers

   logic [1:0] genSync_reg;
   logic [1:0] dataInSync_reg;
   logic genLevel;
   logic dataInLevel;

   always_ff @(posedge clk) begin
      if (reset) begin
         genSync_reg <= 2'h0;
         dataInSync_reg <= 2'h0;
      end else begin
         genSync_reg <= {genSync_reg[0], genPinIn};
         dataInSync_reg <= {dataInSync_reg[0], dataInPinIn};
      end
   end

   assign genLevel = genSync_reg[1];
   assign dataInLevel = dataInSync_reg[1];

   // Function inputs see the pin only in their routed mode
   always_ff @(posedge clk) begin
      if (reset) begin
         genPinRx <= 1'b0;
         dataInPinRx <= 1'b0;
      end else begin
         genPinRx <= (genFunc_reg == GEN_FUNC_INPUT) && genLevel;
         dataInPinRx <= (dataInFunc_reg == DIN_FUNC_INPUT) && dataInLevel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt line shapers

   logic intOnePulse;
   logic intTwoPulse;

   cmpm_int_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_int_one (
      .clk(clk),
      .reset(reset),
      .trigger(intOneEvent),
      .trainMode(trainOne_reg),
      .stop(flagsRead),
      .pulseOut(intOnePulse)
   );

   cmpm_int_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_int_two (
      .clk(clk),
      .reset(reset),
      .trigger(intTwoEvent),
      .trainMode(trainTwo_reg),
      .stop(flagsRead),
      .pulseOut(intTwoPulse)
   );

   always_ff @(posedge clk) begin
      if (reset) begin
         interruptLineOne <= 1'b0;
         interruptLineTwo <= 1'b0;
      end else begin
         interruptLineOne <= intOnePulse;
         interruptLineTwo <= intTwoPulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output multiplexers

   logic genOeNext;
   logic genValNext;
   logic doutOeNext;
   logic doutValNext;
   logic spiOeNext;
   logic spiValNext;

   always_comb begin
      genOeNext = 1'b1;
      genValNext = 1'b0;
      case (genFunc_reg)
         GEN_DIVIDED_CLOCK_OUTPUT: genValNext = dividedClockOut;
         GEN_GP_OUTPUT: genValNext = genGpo_reg;
         GEN_INT_ONE: genValNext = intOnePulse;
         GEN_INT_TWO: genValNext = intTwoPulse;
         GEN_REC_WCLK: genValNext = recWordClk;
         GEN_SEC_BCLK: genValNext = secBitClk;
         GEN_DMIC_CLK: genValNext = dmicClk;
         default: genOeNext = 1'b0;
      endcase
   end

   always_comb begin
      doutOeNext = 1'b1;
      doutValNext = 1'b0;
      unique case (dataOutMux_reg)
         DOUT_DISABLED: doutOeNext = 1'b0;
         DOUT_PRIMARY: doutValNext = priDataOut;
         DOUT_GP_OUTPUT: doutValNext = dataOutGpo_reg;
         DOUT_DIVIDED_CLOCK_OUTPUT: doutValNext = dividedClockOut;
         DOUT_INT_ONE: doutValNext = intOnePulse;
         DOUT_INT_TWO: doutValNext = intTwoPulse;
         DOUT_SEC_BCLK: doutValNext = secBitClk;
         DOUT_SEC_WCLK: doutValNext = secWordClk;
      endcase
   end

   always_comb begin
      spiOeNext = 1'b1;
      spiValNext = 1'b0;
      case (spiFunc_reg)
         SPI_READ_DATA: begin
            spiOeNext = spiMode && spiReadOe;
            spiValNext = spiReadData;
         end
         SPI_GP_OUTPUT: spiValNext = spiGpo_reg;
         SPI_DIVIDED_CLOCK_OUTPUT: spiValNext = dividedClockOut;
         SPI_INT_ONE: spiValNext = intOnePulse;
         SPI_INT_TWO: spiValNext = intTwoPulse;
         SPI_REC_WCLK: spiValNext = recWordClk;
         SPI_DMIC_CLK: spiValNext = dmicClk;
         SPI_SEC_DATA: spiValNext = secDataOut;
         SPI_SEC_BCLK: spiValNext = secBitClk;
         SPI_SEC_WCLK: spiValNext = secWordClk;
         default: spiOeNext = 1'b0;
      endcase
   end

   // Pins come straight from flops; value held low while not driven
   always_ff @(posedge clk) begin
      if (reset) begin
         genPinOe <= 1'b0;
         genPinOut <= 1'b0;
         dataOutPinOe <= 1'b0;
         dataOutPinOut <= 1'b0;
         spiOutPinOe <= 1'b0;
         spiOutPinOut <= 1'b0;
         dataOutKeeperEn <= 1'b0;
      end else begin
         genPinOe <= genOeNext;
         genPinOut <= genOeNext && genValNext;
         dataOutPinOe <= doutOeNext;
         dataOutPinOut <= doutOeNext && doutValNext;
         spiOutPinOe <= spiOeNext;
         spiOutPinOut <= spiOeNext && spiValNext;
         dataOutKeeperEn <= !dataOutKeeperOff_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read path and handshake

   logic [31:0] readWord;

   always_comb begin
      readWord = 32'h0;
      unique case (addrSel)
         SEL_GEN: begin
            readWord[GEN_FUNC_LSB +: 4] = genFunc_reg;
            readWord[GEN_LEVEL_BIT] = genLevel;
            readWord[GEN_GPO_BIT] = genGpo_reg;
         end
         SEL_DOUT: begin
            readWord[DOUT_KEEPER_BIT] = dataOutKeeperOff_reg;
            readWord[DOUT_MUX_LSB +: 3] = dataOutMux_reg;
            readWord[DOUT_GPO_BIT] = dataOutGpo_reg;
         end
         SEL_DIN: begin
            readWord[DIN_FUNC_LSB +: 2] = dataInFunc_reg;
            readWord[DIN_LEVEL_BIT] = dataInLevel;
         end
         SEL_SPI: begin
            readWord[SPI_FUNC_LSB +: 4] = spiFunc_reg;
            readWord[SPI_GPO_BIT] = spiGpo_reg;
         end
         SEL_PULSE: begin
            readWord[TRAIN_ONE_BIT] = trainOne_reg;
            readWord[TRAIN_TWO_BIT] = trainTwo_reg;
         end
         SEL_NONE: readWord = 32'h0;
      endcase
   end

   // Answer on the first access cycle; data captured during setup
   always_ff @(posedge clk) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else if (psel && !penable) begin
         pready <= 1'b1;
         pslverr <= (addrSel == SEL_NONE);
         prdata <= pwrite ? 32'h0 : readWord;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end
   end
endmodule

/* File: core/cmpm_pkg.sv */
// Constants shared by the multi-function pin multiplexer
package cmpm_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_GENERAL_PIN = 8'h34;
   localparam logic [7:0] IDX_DATA_OUT_PIN = 8'h35;
   localparam logic [7:0] IDX_DATA_IN_PIN = 8'h36;
   localparam logic [7:0] IDX_SPI_OUT_PIN = 8'h37;
   localparam logic [7:0] IDX_INT_PULSE_CTRL = 8'h30;

   // General pin register layout
   localparam int GEN_FUNC_LSB = 2;
   localparam int GEN_LEVEL_BIT = 1;
   localparam int GEN_GPO_BIT = 0;
   localparam logic [3:0] GEN_FUNC_RESET = 4'h0;
   localparam logic GEN_GPO_RESET = 1'b0;

   // Data output pin register layout
   localparam int DOUT_KEEPER_BIT = 4;
   localparam int DOUT_MUX_LSB = 1;
   localparam int DOUT_GPO_BIT = 0;
   localparam logic DOUT_KEEPER_RESET = 1'b1;
   localparam logic [2:0] DOUT_MUX_RESET = 3'h1;
   localparam logic DOUT_GPO_RESET = 1'b0;

   // Data input pin register layout
   localparam int DIN_FUNC_LSB = 1;
   localparam int DIN_LEVEL_BIT = 0;
   localparam logic [1:0] DIN_FUNC_RESET = 2'h1;

   // SPI data-out pin register layout
   localparam int SPI_FUNC_LSB = 1;
   localparam int SPI_GPO_BIT = 0;
   localparam logic [3:0] SPI_FUNC_RESET = 4'h1;
   localparam logic SPI_GPO_RESET = 1'b0;

   // Interrupt pulse control layout
   localparam int TRAIN_ONE_BIT = 0;
   localparam int TRAIN_TWO_BIT = 1;
   localparam logic TRAIN_RESET = 1'b0;

   // General pin function codes
   localparam logic [3:0] GEN_DISABLED = 4'h0;
   localparam logic [3:0] GEN_FUNC_INPUT = 4'h1;
   localparam logic [3:0] GEN_GP_INPUT = 4'h2;
   localparam logic [3:0] GEN_DIVIDED_CLOCK_OUTPUT = 4'h3;
   localparam logic [3:0] GEN_GP_OUTPUT = 4'h4;
   localparam logic [3:0] GEN_INT_ONE = 4'h5;
   localparam logic [3:0] GEN_INT_TWO = 4'h6;
   localparam logic [3:0] GEN_REC_WCLK = 4'h7;
   localparam logic [3:0] GEN_SEC_BCLK = 4'h8;
   localparam logic [3:0] GEN_DMIC_CLK = 4'h9;

   // Data output pin mux codes
   localparam logic [2:0] DOUT_DISABLED = 3'h0;
   localparam logic [2:0] DOUT_PRIMARY = 3'h1;
   localparam logic [2:0] DOUT_GP_OUTPUT = 3'h2;
   localparam logic [2:0] DOUT_DIVIDED_CLOCK_OUTPUT = 3'h3;
   localparam logic [2:0] DOUT_INT_ONE = 3'h4;
   localparam logic [2:0] DOUT_INT_TWO = 3'h5;
   localparam logic [2:0] DOUT_SEC_BCLK = 3'h6;
   localparam logic [2:0] DOUT_SEC_WCLK = 3'h7;

   // Data input pin codes
   localparam logic [1:0] DIN_DISABLED = 2'h0;
   localparam logic [1:0] DIN_FUNC_INPUT = 2'h1;
   localparam logic [1:0] DIN_GP_INPUT = 2'h2;

   // SPI data-out pin codes
   localparam logic [3:0] SPI_DISABLED = 4'h0;
   localparam logic [3:0] SPI_READ_DATA = 4'h1;
   localparam logic [3:0] SPI_GP_OUTPUT = 4'h2;
   localparam logic [3:0] SPI_DIVIDED_CLOCK_OUTPUT = 4'h3;
   localparam logic [3:0] SPI_INT_ONE = 4'h4;
   localparam logic [3:0] SPI_INT_TWO = 4'h5;
   localparam logic [3:0] SPI_REC_WCLK = 4'h6;
   localparam logic [3:0] SPI_DMIC_CLK = 4'h7;
   localparam logic [3:0] SPI_SEC_DATA = 4'h8;
   localparam logic [3:0] SPI_SEC_BCLK = 4'h9;
   localparam logic [3:0] SPI_SEC_WCLK = 4'ha;

   // Interrupt pulse timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int INT_PULSE_MS = 2;
   localparam int INT_PULSE_CYCLES = INT_PULSE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int PULSE_CNT_W = 17;

   typedef enum logic [1:0] {PULSE_IDLE, PULSE_HIGH, PULSE_LOW} cmpm_pulse_state_t;
endpackage

/* File: test/cmpm_far_model.sv */
// Audio interface peers: source signals taken from an 8-bit LFSR stepped every cycle
`timescale 1ns/1ps
module cmpm_far_model (
   input logic clk,
   input logic reset,
   output logic spiReadData,
   output logic priDataOut,
   output logic secDataOut,
   output logic dividedClockOut,
   output logic recWordClk,
   output logic secBitClk,
   output logic secWordClk,
   output logic dmicClk
);
   logic [7:0] pat_reg;
   always_ff @(posedge clk) begin
      if (reset) begin
         pat_reg <= 8'h5a;
      end else begin
         pat_reg <= {pat_reg[6:0], pat_reg[7] ^ pat_reg[5] ^ pat_reg[4] ^ pat_reg[3]};
      end
   end
   assign {spiReadData, priDataOut, secDataOut, dividedClockOut} = pat_reg[7:4];
   assign {recWordClk, secBitClk, secWordClk, dmicClk} = pat_reg[3:0];
endmodule

/* File: test/cmpm_pin_mux_checker.sv */
// Bus and pin assertions for the pin multiplexer
`timescale 1ns/1ps
module cmpm_pin_mux_checker #(
   parameter int PULSE_CYCLES = 8
) (
   input logic clk,
   input logic reset,
   input logic psel,
   input logic penable,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic genPinOut,
   input logic genPinOe,
   input logic dataOutPinOut,
   input logic dataOutPinOe,
   input logic spiOutPinOut,
   input logic spiOutPinOe,
   input logic interruptLineOne
);
   logic [31:0] highCnt_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   // High time of the first interrupt line
   always_ff @(posedge clk) begin
      if (reset || !interruptLineOne) begin
         highCnt_reg <= 32'h0;
      end else begin
         highCnt_reg <= highCnt_reg + 32'h1;
      end
   end
   ////////////////////////////////////////
   chk_setup_answer: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero when idle");
   chk_rsvd_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   chk_gen_hiz: assert property (!genPinOe |-> !genPinOut)
      else $error("general pin value while off");
   chk_dout_hiz: assert property (!dataOutPinOe |-> !dataOutPinOut)
      else $error("data out pin value while off");
   chk_spi_hiz: assert property (!spiOutPinOe |-> !spiOutPinOut)
      else $error("spi out pin value while off");
   chk_int_width: assert property ($fell(interruptLineOne) |-> highCnt_reg == PULSE_CYCLES)
      else $error("interrupt pulse width wrong");
   cov_refused: cover property (pready && pslverr);
   cov_int: cover property ($rose(interruptLineOne));
   cov_gen: cover property (genPinOe && genPinOut);
endmodule

bind cmpm_pin_mux cmpm_pin_mux_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.clk, .reset,
   .psel, .penable, .prdata, .pready, .pslverr, .genPinOut, .genPinOe, .dataOutPinOut,
   .dataOutPinOe, .spiOutPinOut, .spiOutPinOe, .interruptLineOne);

/* File: test/tb_top.sv */
// Self-checking bench for the pin multiplexer
`timescale 1ns/1ps
module tb_top
   import cmpm_pkg::*;
;
   localparam int PC = 8;
   logic clk, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic spiMode = 1'b0, spiReadOe = 1'b0, flagsRead = 1'b0;
   logic intOneEvent = 1'b0, intTwoEvent = 1'b0, genPinIn = 1'b0, dataInPinIn = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat, rnd, rv, pg, pd, ps;
   logic pready, pslverr, genPinOut, genPinOe, genPinRx, dataInPinRx, rerr, monOn = 1'b0;
   logic dataOutPinOut, dataOutPinOe, dataOutKeeperEn, spiOutPinOut, spiOutPinOe;
   logic interruptLineOne, interruptLineTwo, spiReadData, priDataOut, secDataOut;
   logic dividedClockOut, recWordClk, secBitClk, secWordClk, dmicClk, ek;
   logic [7:0] shGen = 8'h00, shDout = 8'h12, shSpi = 8'h02;
   logic [3:0] c;
   logic [2:0] eg, ed, es;
   int bad_count = 0, compares = 0;
   int unsigned st = 46;

   cmpm_pin_mux #(.PULSE_CYCLES(PC)) dut (.clk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .spiMode, .spiReadOe, .spiReadData, .priDataOut,
      .secDataOut, .dividedClockOut, .recWordClk, .secBitClk, .secWordClk, .dmicClk,
      .intOneEvent, .intTwoEvent, .flagsRead, .genPinIn, .genPinOut, .genPinOe, .dataInPinIn,
      .genPinRx, .dataInPinRx, .dataOutPinOut, .dataOutPinOe, .dataOutKeeperEn,
      .spiOutPinOut, .spiOutPinOe, .interruptLineOne, .interruptLineTwo);
   cmpm_far_model far (.clk, .reset, .spiReadData, .priDataOut, .secDataOut,
      .dividedClockOut, .recWordClk, .secBitClk, .secWordClk, .dmicClk);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   ////////////////////////////////////////
   function automatic logic [31:0] xs();
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return st;
   endfunction

   // Expected pin: {compare value, enable, value}
   function automatic logic [2:0] pexp(input logic [1:0] p);
      logic s;
      s = 1'b0;
      if (p == 2'd0) begin
         case (shGen[5:2])
            4'h3: s = dividedClockOut;
            GEN_GP_OUTPUT: s = shGen[0];
            4'h5, 4'h6: return 3'b010;
            4'h7: s = recWordClk;
            4'h8: s = secBitClk;
            4'h9: s = dmicClk;
            default: return 3'b100;
         endcase
      end else if (p == 2'd1) begin
         case (shDout[3:1])
            3'h0: return 3'b100;
            3'h1: s = priDataOut;
            3'h2: s = shDout[0];
            3'h3: s = dividedClockOut;
            3'h4, 3'h5: return 3'b010;
            3'h6: s = secBitClk;
            3'h7: s = secWordClk;
         endcase
      end else begin
         case (shSpi[4:1])
            4'h1: begin
               if (!(spiMode && spiReadOe)) return 3'b100;
               s = spiReadData;
            end
            4'h2: s = shSpi[0];
            4'h3: s = dividedClockOut;
            4'h4, 4'h5: return 3'b010;
            4'h6: s = recWordClk;
            4'h7: s = dmicClk;
            4'h8: s = secDataOut;
            4'h9: s = secBitClk;
            4'ha: s = secWordClk;
            default: return 3'b100;
         endcase
      end
      return {2'b11, s};
   endfunction

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk("pready", 32'h1, {31'h0, pready});
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (w && a[1:0] == 2'b00 && a[31:10] == 22'h0) begin
         case (a[9:2])
            IDX_GENERAL_PIN: shGen <= d[7:0] & 8'h3d;
            IDX_DATA_OUT_PIN: shDout <= d[7:0] & 8'h1f;
            IDX_SPI_OUT_PIN: shSpi <= d[7:0] & 8'h1f;
            default: ;
         endcase
      end
   endtask

   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      apb(1'b1, {22'h0, i, 2'b00}, {24'h0, d});
   endtask

   task automatic rd(input logic [7:0] i, input logic [31:0] e);
      apb(1'b0, {22'h0, i, 2'b00}, 32'h0);
      chk("rdata", e, rdat);
   endtask

   task automatic irq(input logic ln, input logic tr);
      wr(IDX_INT_PULSE_CTRL, {6'h0, ln & tr, !ln & tr});
      @(posedge clk);
      if (ln) intTwoEvent <= 1'b1;
      else intOneEvent <= 1'b1;
      @(posedge clk);
      intOneEvent <= 1'b0;
      intTwoEvent <= 1'b0;
      #1 chk("intEarly", 32'h0, {31'h0, ln ? interruptLineTwo : interruptLineOne});
      @(posedge clk);
      #1 chk("intRise", 32'h1, {31'h0, ln ? interruptLineTwo : interruptLineOne});
      chk("intPin", 32'h1, {31'h0, ln ? spiOutPinOut : genPinOut && dataOutPinOut});
      repeat (PC) @(posedge clk);
      #1 chk("intFall", 32'h0, {31'h0, ln ? interruptLineTwo : interruptLineOne});
      if (tr) begin
         repeat (PC) @(posedge clk);
         #1 chk("intTrain", 32'h1, {31'h0, ln ? interruptLineTwo : interruptLineOne});
         @(posedge clk);
         flagsRead <= 1'b1;
         @(posedge clk);
         flagsRead <= 1'b0;
         repeat (2 * PC) @(posedge clk);
         #1 chk("intStop", 32'h0, {31'h0, ln ? interruptLineTwo : interruptLineOne});
      end
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   always @(posedge clk) begin
      rv = xs();
      spiMode <= rv[0];
      spiReadOe <= rv[1];
   end

   always @(posedge clk) begin
      if (monOn) begin
         eg = pexp(2'd0);
         ed = pexp(2'd1);
         es = pexp(2'd2);
         ek = !shDout[4];
         #1;
         pg = {30'h0, genPinOe, eg[2] ? genPinOut : eg[0]};
         pd = {30'h0, dataOutPinOe, ed[2] ? dataOutPinOut : ed[0]};
         ps = {30'h0, spiOutPinOe, es[2] ? spiOutPinOut : es[0]};
         chk("genPin", {30'h0, eg[1:0]}, pg);
         chk("doutPin", {30'h0, ed[1:0]}, pd);
         chk("spiPin", {30'h0, es[1:0]}, ps);
         chk("keeper", {31'h0, ek}, {31'h0, dataOutKeeperEn});
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      give_verdict();
   end
   ////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      monOn <= 1'b1;
      rd(IDX_GENERAL_PIN, 32'h0);
      rd(IDX_DATA_OUT_PIN, 32'h12);
      rd(IDX_DATA_IN_PIN, 32'h2);
      rd(IDX_SPI_OUT_PIN, 32'h2);
      apb(1'b0, 32'he0, 32'h0);
      chk("slverr", 32'h1, {31'h0, rerr});
      apb(1'b1, 32'hd1, 32'h24);
      chk("slverr", 32'h1, {31'h0, rerr});
      rd(IDX_GENERAL_PIN, 32'h0);
      wr(IDX_DATA_OUT_PIN, 8'h1f);
      rd(IDX_DATA_OUT_PIN, 32'h1f);
      for (int i = 0; i < 51; i++) begin
         rnd = xs();
         c = (i < 11) ? i[3:0] : rnd[7:4] % 4'hb;
         wr(IDX_GENERAL_PIN, {2'b00, c, 1'b0, rnd[0]});
         wr(IDX_DATA_OUT_PIN, {3'b000, rnd[1], c[2:0], rnd[2]});
         wr(IDX_SPI_OUT_PIN, {3'b000, c, rnd[3]});
         rd(IDX_GENERAL_PIN, {24'h0, shGen});
         rd(IDX_SPI_OUT_PIN, {24'h0, shSpi});
         repeat (3) @(posedge clk);
      end
      wr(IDX_GENERAL_PIN, 8'h04);
      genPinIn <= 1'b1;
      dataInPinIn <= 1'b1;
      repeat (5) @(posedge clk);
      #1 chk("genRx", 32'h1, {31'h0, genPinRx});
      chk("dinRx", 32'h1, {31'h0, dataInPinRx});
      rd(IDX_GENERAL_PIN, 32'h06);
      rd(IDX_DATA_IN_PIN, 32'h03);
      wr(IDX_GENERAL_PIN, 8'h08);
      wr(IDX_DATA_IN_PIN, 8'h04);
      repeat (3) @(posedge clk);
      #1 chk("dinRx", 32'h0, {31'h0, dataInPinRx});
      rd(IDX_GENERAL_PIN, 32'h0a);
      rd(IDX_DATA_IN_PIN, 32'h05);
      wr(IDX_GENERAL_PIN, 8'h14);
      wr(IDX_DATA_OUT_PIN, 8'h08);
      wr(IDX_SPI_OUT_PIN, 8'h0a);
      for (int ln = 0; ln < 2; ln++) begin
         irq(ln[0], 1'b0);
         irq(ln[0], 1'b1);
      end
      give_verdict();
   end
endmodule
